// *** hw/dsrf_top.sv ***
/*
 * Dual processing-element datapath: per element a 32-entry banked register file, ALU,
 * multiplier with banked result register and shifter, plus two memory bus ports with
 * banked address pointers.
 * Assumes mode bits, instruction fields and bus requests are synchronous to mclk_in.
 */
`include "dsrf_params.svh"

module dsrf_top #(
    parameter int DATA_W = `DSRF_DATA_W,
    parameter int WORD_W = `DSRF_WORD_W,
    parameter int ADDR_W = `DSRF_ADDR_W
) (
    input  wire logic                               mclk_in,
    input  wire logic                               rst_b_in,
    input  wire logic                               second_element_enable_in,
    input  wire logic                               data_bank_sel_in,
    input  wire logic                               agen_bank_sel_in,
    input  wire logic                               mul_bank_sel_in,
    input  wire logic                               issue_valid_in,
    input  wire dsrf_pkg::dsrf_alu_op_t             alu_op_in,
    input  wire dsrf_pkg::dsrf_mul_op_t             mul_op_in,
    input  wire dsrf_pkg::dsrf_shf_op_t             shf_op_in,
    input  wire dsrf_pkg::dsrf_fmt_t                fmt_in,
    input  wire logic [`DSRF_IDX_W-1:0]             src_a_in,
    input  wire logic [`DSRF_IDX_W-1:0]             src_b_in,
    input  wire logic [`DSRF_IDX_W-1:0]             src_c_in,
    input  wire logic [`DSRF_IDX_W-1:0]             src_d_in,
    input  wire logic [`DSRF_IDX_W-1:0]             alu_dst_in,
    input  wire logic [`DSRF_IDX_W-1:0]             mul_dst_in,
    input  wire logic [`DSRF_IDX_W-1:0]             shf_dst_in,
    input  wire logic                               dm_valid_in,
    input  wire logic                               dm_load_in,
    input  wire logic                               dm_async_in,
    input  wire logic [`DSRF_IDX_W-1:0]             dm_reg_in,
    input  wire logic [2*WORD_W-1:0]                dm_data_in,
    input  wire logic                               pm_valid_in,
    input  wire logic                               pm_load_in,
    input  wire logic                               pm_async_in,
    input  wire logic [`DSRF_IDX_W-1:0]             pm_reg_in,
    input  wire logic [2*WORD_W-1:0]                pm_data_in,
    output logic      [2*WORD_W-1:0]                dm_data_out,
    output logic      [ADDR_W-1:0]                  dm_addr_out,
    output logic      [2*WORD_W-1:0]                pm_data_out,
    output logic      [ADDR_W-1:0]                  pm_addr_out,
    output logic      [`DSRF_NPE-1:0][DATA_W-1:0]   alu_result_out,
    output logic      [`DSRF_NPE-1:0]               result_zero_out
);
    import dsrf_pkg::*;

    localparam int PAD_W = DATA_W - WORD_W;
    localparam logic [PAD_W-1:0] PAD0 = '0;

    // ======================================================================
    // Element enables and pairing
    wire [`DSRF_NPE-1:0]             pe_on;
    wire [`DSRF_NPE-1:0]             alu_we_c;
    wire [`DSRF_NPE-1:0]             mul_we_c;
    wire [`DSRF_NPE-1:0]             any_we_c;
    wire [`DSRF_NPE-1:0][DATA_W-1:0] alu_res_c;
    wire [`DSRF_NPE-1:0][WORD_W-1:0] dm_rd_c;
    wire [`DSRF_NPE-1:0][WORD_W-1:0] pm_rd_c;
    // The async port is 32 bits wide outside; it never pairs
    wire dm_pair = second_element_enable_in && !dm_async_in;
    wire pm_pair = second_element_enable_in && !pm_async_in;

    // ======================================================================
    // Processing elements
    for (genvar e = 0; e < `DSRF_NPE; e++) begin : gen_pe
        logic [DATA_W-1:0]   rf [0:`DSRF_NREG-1];
        logic [2*WORD_W-1:0] mr [0:1];
        logic [DATA_W-1:0]   va, vb, vc, vd, alu_r, shf_r, mul_r;
        logic [WORD_W-1:0]   a32, b32, c32, d32;
        logic [2*WORD_W-1:0] prod, cur_mr, next_mr;
        logic [`DSRF_SHAMT_W-1:0] amt;
        logic                mem_dm, mem_pm, alu_we, mul_we, shf_we, mr_we;

        assign pe_on[e] = (e == 0) || second_element_enable_in;
        // Bank select forms the top index bit: 0 picks the primary sixteen
        assign va = rf[{data_bank_sel_in, src_a_in}];
        assign vb = rf[{data_bank_sel_in, src_b_in}];
        assign vc = rf[{data_bank_sel_in, src_c_in}];
        assign vd = rf[{data_bank_sel_in, src_d_in}];
        assign a32 = va[DATA_W-1 -: WORD_W];
        assign b32 = vb[DATA_W-1 -: WORD_W];
        assign c32 = vc[DATA_W-1 -: WORD_W];
        assign d32 = vd[DATA_W-1 -: WORD_W];
        assign amt = vb[PAD_W +: `DSRF_SHAMT_W];
        assign prod = c32 * d32;
        assign cur_mr = mr[mul_bank_sel_in];

        assign alu_we = issue_valid_in && pe_on[e] && (alu_op_in != ALU_NOP);
        assign mul_we = issue_valid_in && pe_on[e] && (mul_op_in inside {MUL_MUL, MUL_MAC});
        assign mr_we  = issue_valid_in && pe_on[e] && (mul_op_in != MUL_NOP);
        assign shf_we = issue_valid_in && pe_on[e] && (shf_op_in != SHF_NOP);
        assign mem_dm = (e == 0) || dm_pair;
        assign mem_pm = (e == 0) || pm_pair;

        assign alu_we_c[e]  = alu_we;
        assign mul_we_c[e]  = mul_we;
        assign any_we_c[e]  = alu_we || mul_we || shf_we || (mem_dm && dm_valid_in && dm_load_in)
                              || (mem_pm && pm_valid_in && pm_load_in) || mr_we;
        assign alu_res_c[e] = alu_r;
        assign dm_rd_c[e] = mem_dm ? rf[{data_bank_sel_in, dm_reg_in}][DATA_W-1 -: WORD_W] : '0;
        assign pm_rd_c[e] = mem_pm ? rf[{data_bank_sel_in, pm_reg_in}][DATA_W-1 -: WORD_W] : '0;

        // Float add is not done here; float formats only steer sign and rounding
        always_comb begin
            alu_r = '0;
            case (alu_op_in)
                ALU_ADD:  alu_r = {a32 + b32, PAD0};
                ALU_SUB:  alu_r = {a32 - b32, PAD0};
                ALU_AND:  alu_r = va & vb;
                ALU_OR:   alu_r = va | vb;
                ALU_PASS: alu_r = va;
                ALU_NEG:  alu_r = (fmt_in == FMT_FIXED) ? {-a32, PAD0} : {~va[DATA_W-1], va[DATA_W-2:0]};
                ALU_ABS:  alu_r = (fmt_in == FMT_FIXED) ? {(a32[WORD_W-1] ? -a32 : a32), PAD0}
                                                        : {1'b0, va[DATA_W-2:0]};
                default:  alu_r = '0;
            endcase
            if (fmt_in == FMT_SINGLE) begin
                alu_r[PAD_W-1:0] = PAD0;
            end
        end

        always_comb begin
            case (shf_op_in)
                SHF_LSL: shf_r = {a32 << amt, PAD0};
                SHF_LSR: shf_r = {a32 >> amt, PAD0};
                SHF_ASR: shf_r = {$signed(a32) >>> amt, PAD0};
                default: shf_r = '0;
            endcase
            case (mul_op_in)
                MUL_MUL: next_mr = prod;
                MUL_MAC: next_mr = cur_mr + prod;
                MUL_CLR: next_mr = '0;
                default: next_mr = cur_mr;
            endcase
            mul_r = {next_mr[WORD_W-1:0], PAD0};
        end

        // Later ports win on a shared destination: shifter, multiplier, ALU, data, program
        always_ff @(posedge mclk_in) begin
            if (rst_b_in) begin
                if (shf_we) begin
                    rf[{data_bank_sel_in, shf_dst_in}] <= shf_r;
                end
                if (mul_we) begin
                    rf[{data_bank_sel_in, mul_dst_in}] <= mul_r;
                end
                if (alu_we) begin
                    rf[{data_bank_sel_in, alu_dst_in}] <= alu_r;
                end
                if (mem_dm && dm_valid_in && dm_load_in) begin
                    rf[{data_bank_sel_in, dm_reg_in}] <= {dm_data_in[e*WORD_W +: WORD_W], PAD0};
                end
                if (mem_pm && pm_valid_in && pm_load_in) begin
                    rf[{data_bank_sel_in, pm_reg_in}] <= {pm_data_in[e*WORD_W +: WORD_W], PAD0};
                end
            end
        end

        always_ff @(posedge mclk_in) begin
            if (!rst_b_in) begin
                mr[0] <= `DSRF_MR_RST;
                mr[1] <= `DSRF_MR_RST;
            end else if (mr_we) begin
                mr[mul_bank_sel_in] <= next_mr;
            end
        end
    end

    // ======================================================================
    // Address pointers, one pair of banks per bus
    logic [ADDR_W-1:0] dm_ptr [0:1];
    logic [ADDR_W-1:0] pm_ptr [0:1];

    always_ff @(posedge mclk_in) begin
        if (!rst_b_in) begin
            dm_ptr[0]   <= ADDR_W'(`DSRF_AGEN_RST);
            dm_ptr[1]   <= ADDR_W'(`DSRF_AGEN_RST);
            pm_ptr[0]   <= ADDR_W'(`DSRF_AGEN_RST);
            pm_ptr[1]   <= ADDR_W'(`DSRF_AGEN_RST);
            dm_addr_out <= ADDR_W'(`DSRF_AGEN_RST);
            pm_addr_out <= ADDR_W'(`DSRF_AGEN_RST);
        end else begin
            if (dm_valid_in) begin
                dm_addr_out <= dm_ptr[agen_bank_sel_in];
                dm_ptr[agen_bank_sel_in] <= dm_ptr[agen_bank_sel_in]
                    + (dm_pair ? ADDR_W'(`DSRF_STEP_PAIR) : ADDR_W'(`DSRF_STEP_SINGLE));
            end
            if (pm_valid_in) begin
                pm_addr_out <= pm_ptr[agen_bank_sel_in];
                pm_ptr[agen_bank_sel_in] <= pm_ptr[agen_bank_sel_in]
                    + (pm_pair ? ADDR_W'(`DSRF_STEP_PAIR) : ADDR_W'(`DSRF_STEP_SINGLE));
            end
        end
    end

    // ======================================================================
    // Bus read data and result outputs
    always_ff @(posedge mclk_in) begin
        if (!rst_b_in) begin
            dm_data_out <= '0;
            pm_data_out <= '0;
        end else begin
            if (dm_valid_in && !dm_load_in) begin
                dm_data_out <= {dm_rd_c[1], dm_rd_c[0]};
            end
            if (pm_valid_in && !pm_load_in) begin
                pm_data_out <= {pm_rd_c[1], pm_rd_c[0]};
            end
        end
    end

    always_ff @(posedge mclk_in) begin
        if (!rst_b_in) begin
            alu_result_out  <= '0;
            result_zero_out <= '0;
        end else begin
            for (int i = 0; i < `DSRF_NPE; i++) begin
                if (alu_we_c[i]) begin
                    alu_result_out[i]  <= alu_res_c[i];
                    result_zero_out[i] <= (alu_res_c[i] == '0);
                end
            end
        end
    end

    // ======================================================================
    // Checks
    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (!rst_b_in);

    chk_primary_alive: assert property (
        issue_valid_in && alu_op_in != ALU_NOP |-> alu_we_c[0])
        else $error("primary element skipped an ALU operation");
    chk_secondary_frozen: assert property (
        !second_element_enable_in |-> !any_we_c[1])
        else $error("secondary element written while disabled");
    chk_simd_both: assert property (
        issue_valid_in && second_element_enable_in && alu_op_in != ALU_NOP |-> alu_we_c == 2'h3)
        else $error("SIMD instruction not run in both elements");
    chk_pair_transfer: assert property (
        dm_valid_in && !dm_load_in && dm_pair |=> dm_data_out == $past({dm_rd_c[1], dm_rd_c[0]}))
        else $error("paired read did not return both element values");
    chk_async_single: assert property (
        dm_valid_in && !dm_load_in && dm_async_in |=> dm_data_out[2*WORD_W-1:WORD_W] == '0)
        else $error("async port access was paired");
    chk_primary_bank: assert property (
        !data_bank_sel_in && alu_we_c[0] && !dm_valid_in && !pm_valid_in && mul_op_in == MUL_NOP
        && shf_op_in == SHF_NOP |=> gen_pe[0].rf[$past({1'b0, alu_dst_in})] == $past(alu_res_c[0]))
        else $error("primary bank not written");
    chk_agen_bank: assert property (
        dm_valid_in |=> dm_addr_out == $past(dm_ptr[agen_bank_sel_in]))
        else $error("address not taken from selected pointer bank");
    chk_single_cycle: assert property (
        issue_valid_in && alu_op_in == ALU_ADD && fmt_in == FMT_FIXED
        |=> alu_result_out[0][DATA_W-1 -: WORD_W] == $past(gen_pe[0].a32 + gen_pe[0].b32))
        else $error("ALU sum not ready after one cycle");
    chk_multifunction: assert property (
        issue_valid_in && second_element_enable_in && alu_op_in != ALU_NOP
        && mul_op_in inside {MUL_MUL, MUL_MAC} |-> alu_we_c == 2'h3 && mul_we_c == 2'h3)
        else $error("multifunction pair not concurrent");
    chk_float_neg: assert property (
        issue_valid_in && alu_op_in == ALU_NEG && fmt_in == FMT_EXT
        |=> alu_result_out[0][DATA_W-1] != $past(gen_pe[0].va[DATA_W-1]))
        else $error("extended negate did not flip sign");
    chk_dual_bus: assert property (
        dm_valid_in && !dm_load_in && pm_valid_in && !pm_load_in
        |=> dm_data_out[WORD_W-1:0] == $past(dm_rd_c[0]) && pm_data_out[WORD_W-1:0] == $past(pm_rd_c[0]))
        else $error("both buses did not transfer in the same cycle");

endmodule : dsrf_top

// *** hw/dsrf_params.svh ***
/*
 * Constants of the dual-element register file: widths, counts, reset values and steps.
 * Assumes it is included by its bare name from the package and the design module.
 */
`ifndef DSRF_PARAMS_SVH
`define DSRF_PARAMS_SVH

// ==========================================================================
// Data widths
`define DSRF_DATA_W      40
`define DSRF_WORD_W      32
`define DSRF_PAD_W       8
`define DSRF_ADDR_W      24
`define DSRF_SHAMT_W     5

// ==========================================================================
// Register file geometry
`define DSRF_NPE         2
`define DSRF_NREG        32
`define DSRF_BANK_REGS   16
`define DSRF_IDX_W       4

// ==========================================================================
// Reset values and address steps
`define DSRF_AGEN_RST    24'h000000
`define DSRF_STEP_SINGLE 24'h000001
`define DSRF_STEP_PAIR   24'h000002
`define DSRF_MR_RST      64'h0000000000000000

`endif

// *** hw/dsrf_pkg.sv ***
/*
 * Types shared by the dual-element register file and its bench: operation and format codes.
 * Assumes dsrf_params.svh is on the include path.
 */
`include "dsrf_params.svh"

package dsrf_pkg;

    // ======================================================================
    // Operation codes
    typedef enum logic [2:0] {
        ALU_NOP, ALU_ADD, ALU_SUB, ALU_AND, ALU_OR, ALU_PASS, ALU_NEG, ALU_ABS
    } dsrf_alu_op_t;

    typedef enum logic [1:0] {
        MUL_NOP, MUL_MUL, MUL_MAC, MUL_CLR
    } dsrf_mul_op_t;

    typedef enum logic [1:0] {
        SHF_NOP, SHF_LSL, SHF_LSR, SHF_ASR
    } dsrf_shf_op_t;

    // Fixed and single hold 32 bits left-aligned; extended uses all 40
    typedef enum logic [1:0] {
        FMT_FIXED, FMT_SINGLE, FMT_EXT
    } dsrf_fmt_t;

endpackage : dsrf_pkg

// *** sim/dsrf_mem_model.sv ***
/*
 * On-chip memory seen from one memory bus: answers load requests with a 64-bit word.
 * Assumes the bench hands it the word to return and drives requests off mclk_in.
 */
module dsrf_mem_model (
    input  wire logic        mclk_in,
    input  wire logic        valid_in,
    input  wire logic        load_in,
    input  wire logic [63:0] word_in,
    output logic      [63:0] data_out
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [63:0] last;
    initial last = 64'h0;
    // ======================================================================
    // Full 64-bit word in the request cycle, on load requests only
    always @(posedge mclk_in) begin
        if (valid_in && load_in) begin
            last <= word_in;
        end
    end
    // Idle bus never repeats the last word, so a stale capture is seen
    assign data_out = (valid_in && load_in) ? word_in : ~last;
endmodule : dsrf_mem_model

// *** sim/dual_element_simd_register_file_bench.sv ***
/*
 * Self-checking bench: a driver notes expected results in a queue, a watcher compares them.
 * Assumes dsrf_pkg, dsrf_top and dsrf_mem_model are compiled before it.
 */
module dual_element_simd_register_file_bench;
    timeunit 1ns;
    timeprecision 1ns;
    import dsrf_pkg::*;
    typedef struct packed {
        logic en, dbank, abank, mbank, iv;
        dsrf_alu_op_t alu; dsrf_mul_op_t mul; dsrf_shf_op_t shf; dsrf_fmt_t fmt;
        logic [3:0] a, b, c, d, ad, md, sd;
        logic dv, dl, da; logic [3:0] dr; logic [63:0] dw;
        logic pv, pl, pa; logic [3:0] pr; logic [63:0] pw;
    } dsrf_drive_t;
    typedef struct {int due; int sel; logic [63:0] exp;} dsrf_note_t;
    logic             mclk_in = 1'b0;
    logic             rst_b_in;
    dsrf_drive_t      dr, sh;
    logic [63:0]      dm_din, pm_din, dm_dout, pm_dout, got;
    logic [23:0]      dm_addr, pm_addr;
    logic [1:0][39:0] alu_res;
    logic [1:0]       zro;
    logic [31:0]      p1, p2, s1, s2, p7, s7, p9, s9;
    int               cyc, fail_count, cmp_count;
    dsrf_note_t       q[$];
    dsrf_alu_op_t     ops[5] = '{ALU_ADD, ALU_SUB, ALU_AND, ALU_OR, ALU_PASS};
    string            nm[7] = '{"dm_data", "dm_addr", "pm_data", "pm_addr", "alu0", "alu1", "zero"};

    always #50 mclk_in = ~mclk_in;

    dsrf_mem_model dm_mem (.mclk_in(mclk_in), .valid_in(dr.dv), .load_in(dr.dl), .word_in(dr.dw), .data_out(dm_din));
    dsrf_mem_model pm_mem (.mclk_in(mclk_in), .valid_in(dr.pv), .load_in(dr.pl), .word_in(dr.pw), .data_out(pm_din));

    dsrf_top DUT (
        .mclk_in(mclk_in), .rst_b_in(rst_b_in), .second_element_enable_in(dr.en),
        .data_bank_sel_in(dr.dbank), .agen_bank_sel_in(dr.abank), .mul_bank_sel_in(dr.mbank),
        .issue_valid_in(dr.iv), .alu_op_in(dr.alu), .mul_op_in(dr.mul), .shf_op_in(dr.shf), .fmt_in(dr.fmt),
        .src_a_in(dr.a), .src_b_in(dr.b), .src_c_in(dr.c), .src_d_in(dr.d),
        .alu_dst_in(dr.ad), .mul_dst_in(dr.md), .shf_dst_in(dr.sd),
        .dm_valid_in(dr.dv), .dm_load_in(dr.dl), .dm_async_in(dr.da), .dm_reg_in(dr.dr), .dm_data_in(dm_din),
        .pm_valid_in(dr.pv), .pm_load_in(dr.pl), .pm_async_in(dr.pa), .pm_reg_in(dr.pr), .pm_data_in(pm_din),
        .dm_data_out(dm_dout), .dm_addr_out(dm_addr), .pm_data_out(pm_dout), .pm_addr_out(pm_addr),
        .alu_result_out(alu_res), .result_zero_out(zro)
    );

    // ======================================================================
    // Helpers
    function automatic logic [63:0] pk(input logic [31:0] x);
        return {24'h000000, x, 8'h00};
    endfunction : pk
    function automatic logic [31:0] fn(input dsrf_alu_op_t op, input logic [31:0] x, input logic [31:0] y);
        case (op)
            ALU_ADD: return x + y;
            ALU_SUB: return x - y;
            ALU_AND: return x & y;
            ALU_OR:  return x | y;
            default: return x;
        endcase
    endfunction : fn
    // One NBA copy per edge, so no input is written twice in a time step
    task automatic tick;
        @(posedge mclk_in);
        dr <= sh;
        sh.iv = 1'b0;
        sh.dv = 1'b0;
        sh.pv = 1'b0;
    endtask : tick
    task automatic note(input int sel, input logic [63:0] e);
        q.push_back('{cyc + 2, sel, e});
    endtask : note
    task automatic dm(input logic l, input logic a, input logic [3:0] r, input logic [63:0] w);
        sh.dv = 1'b1; sh.dl = l; sh.da = a; sh.dr = r; sh.dw = w;
    endtask : dm
    task automatic pm(input logic l, input logic a, input logic [3:0] r, input logic [63:0] w);
        sh.pv = 1'b1; sh.pl = l; sh.pa = a; sh.pr = r; sh.pw = w;
    endtask : pm
    task automatic alu(input dsrf_alu_op_t op, input logic [3:0] a, input logic [3:0] b, input logic [3:0] t);
        sh.iv = 1'b1; sh.alu = op; sh.a = a; sh.b = b; sh.ad = t; sh.mul = MUL_NOP;
    endtask : alu
    task automatic final_report;
        if (fail_count == 0 && cmp_count > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : final_report

    // ======================================================================
    // Watcher: oldest note is compared when its result is due
    always @(negedge mclk_in) begin
        cyc = cyc + 1;
        while (q.size() > 0 && q[0].due <= cyc) begin
            case (q[0].sel)
                0: got = dm_dout;
                1: got = 64'(dm_addr);
                2: got = pm_dout;
                3: got = 64'(pm_addr);
                4: got = 64'(alu_res[0]);
                5: got = 64'(alu_res[1]);
                default: got = 64'(zro);
            endcase
            cmp_count++;
            if (got !== q[0].exp) begin
                $display("[ERR] %s expected %h seen %h", nm[q[0].sel], q[0].exp, got);
                fail_count++;
            end
            void'(q.pop_front());
        end
    end

    // ======================================================================
    // Scenarios
    initial begin
        dr = '0; sh = '0; rst_b_in = 1'b0; cyc = 0; fail_count = 0; cmp_count = 0;
        void'($urandom(32'hFC170036));
        p1 = $urandom; p2 = $urandom; s1 = $urandom; s2 = $urandom;
        p7 = $urandom; s7 = $urandom; p9 = $urandom; s9 = $urandom;
        repeat (3) @(posedge mclk_in);
        rst_b_in <= 1'b1;
        tick;
        for (int i = 0; i < 7; i++) note(i, 64'h0);
        sh.en = 1'b1;
        dm(1'b1, 1'b0, 4'h1, {s1, p1}); pm(1'b1, 1'b0, 4'h2, {s2, p2}); tick;
        note(1, 64'h0); note(3, 64'h0);
        alu(ALU_ADD, 4'h1, 4'h2, 4'h3); sh.mul = MUL_MUL; sh.c = 4'h1; sh.d = 4'h2; sh.md = 4'h4; tick;
        note(4, pk(p1 + p2)); note(5, pk(s1 + s2));
        dm(1'b0, 1'b0, 4'h3, 64'h0); pm(1'b0, 1'b0, 4'h4, 64'h0); tick;
        note(0, {s1 + s2, p1 + p2}); note(1, 64'h2);
        note(2, {32'(s1 * s2), 32'(p1 * p2)}); note(3, 64'h2);
        dm(1'b0, 1'b1, 4'h3, 64'h0); tick;
        note(0, {32'h0, p1 + p2}); note(1, 64'h4);
        foreach (ops[i]) begin
            alu(ops[i], 4'h1, 4'h2, 4'h5); tick;
            note(4, pk(fn(ops[i], p1, p2))); note(5, pk(fn(ops[i], s1, s2)));
        end
        alu(ALU_SUB, 4'h1, 4'h1, 4'h6); tick;
        note(6, 64'h3);
        sh.en = 1'b0; dm(1'b1, 1'b0, 4'h1, {s9, p9}); tick;
        note(1, 64'h5);
        alu(ALU_ADD, 4'h1, 4'h2, 4'h3); tick;
        note(4, pk(p9 + p2)); note(5, 64'h0);
        sh.en = 1'b1; dm(1'b0, 1'b0, 4'h1, 64'h0); tick;
        note(0, {s1, p9}); note(1, 64'h6);
        sh.dbank = 1'b1; sh.abank = 1'b1; dm(1'b1, 1'b0, 4'h1, {s7, p7}); tick;
        note(1, 64'h0);
        sh.dbank = 1'b0; sh.abank = 1'b0; dm(1'b0, 1'b0, 4'h1, 64'h0); tick;
        note(0, {s1, p9}); note(1, 64'h8);
        sh.dbank = 1'b1; sh.mbank = 1'b1; dm(1'b0, 1'b0, 4'h1, 64'h0); tick;
        note(0, {s7, p7}); note(1, 64'hA);
        // Sign handling differs by format, so both paths are driven
        alu(ALU_NEG, 4'h1, 4'h1, 4'h6); sh.fmt = FMT_EXT; tick;
        note(4, pk(p7 ^ 32'h80000000)); note(5, pk(s7 ^ 32'h80000000));
        alu(ALU_ABS, 4'h1, 4'h1, 4'h6); sh.fmt = FMT_FIXED; tick;
        note(4, pk(p7[31] ? -p7 : p7)); note(5, pk(s7[31] ? -s7 : s7));
        tick;
        for (int k = 0; k < 10 && q.size() > 0; k++) @(posedge mclk_in);
        if (q.size() > 0) fail_count++;
        final_report();
    end
endmodule : dual_element_simd_register_file_bench
